// file: sim/gpcfg_pads.sv
// Pad model: wire level of each pin from device drive and outside level
module gpcfg_pads (
    input  wire logic [6:0] pin_o,
    input  wire logic [6:0] pin_oe_n,
    input  wire logic [6:0] ext_level,
    output logic      [6:0] pin_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released pins follow the outside level, driven pins read back pin_o
    assign pin_i = (pin_oe_n & ext_level) | (~pin_oe_n & pin_o);
endmodule // gpcfg_pads

// file: sim/gpio_pin_config_bank_tb_top.sv
// Self-checking bench for the pin configuration bank
`include "gpcfg_map.svh"
module gpio_pin_config_bank_tb_top;
    import gpcfg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk, hresetn, hsel, hwrite, hready, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [6:0]  pin_i, pin_o, pin_oe_n, ext;
    logic        ri_n, dcd_n, rxd, dsr_n, txd, rts_n;
    gpcfg_byte_t disable_register;
    int          n_errors, num_checks;
    logic        hreadyout_w;
    assign hready = hreadyout_w;
    gpcfg_bank uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout_w), .hresp(hresp), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe_n(pin_oe_n),
        .port2_ring_indicator_n(ri_n), .port2_carrier_detect_n(dcd_n),
        .port2_receive_data(rxd), .port2_transmit_data(txd),
        .port2_data_set_ready_n(dsr_n), .port2_request_to_send_n(rts_n),
        .disable_register(disable_register), .irq(irq));
    gpcfg_pads pads (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .ext_level(ext),
        .pin_i(pin_i));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    function automatic logic [31:0] ad(input logic [7:0] i);
        return {22'h0, i, 2'b00};
    endfunction
    // Single word transfer; address phase held until hready, then data
    task automatic xfer(input logic [31:0] a, input logic w,
                        input logic [31:0] d);
        @(posedge hclk);
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        #1;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        xfer(ad(i), 1'b1, {24'h0, d});
    endtask
    task automatic rd_chk(input logic [7:0] i, input logic [7:0] m,
                          input logic [7:0] e);
        xfer(ad(i), 1'b0, 32'h0000_0000);
        check(rd & {24'h0, m}, {24'h0, e});
    endtask
    task automatic settle();
        repeat (5) @(posedge hclk);
        #1;
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Whole run is under two hundred cycles; this is about a hundred times that
    initial begin
        #200000;
        n_errors++;
        stop_test();
    end
    initial begin
        hresetn = 1'b0; hsel = 1'b1; haddr = 32'h0000_0000; htrans = 2'b00;
        hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0000_0000;
        ext = 7'h7f; txd = 1'b1; rts_n = 1'b1;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 7; i++)
            rd_chk(8'h3e + 8'(i), 8'hff, (i == 4) ? 8'h00 : 8'h01);
        check({25'h0, pin_oe_n}, 32'h0000_006f);
        wr(8'h60, 8'h5a);
        rd_chk(8'h60, 8'hff, 8'h00);
        $display("test reset values done");
        wr(`GPCFG_IDX_RING, 8'hff);
        rd_chk(`GPCFG_IDX_RING, 8'hff, 8'h8f);
        wr(`GPCFG_IDX_DATA, 8'h00);
        wr(`GPCFG_IDX_RING, 8'h00);
        check({pin_oe_n[1], pin_o[1]}, 2'b00);
        wr(`GPCFG_IDX_RING, 8'h02);
        check({pin_oe_n[1], pin_o[1]}, 2'b01);
        wr(`GPCFG_IDX_RING, 8'h82);
        check(pin_oe_n[1], 1'b1);
        wr(`GPCFG_IDX_RING, 8'h80);
        check({pin_oe_n[1], pin_o[1]}, 2'b00);
        wr(`GPCFG_IDX_RING, 8'h03);
        settle();
        rd_chk(`GPCFG_IDX_PINS, 8'h02, 8'h00);
        check(pin_oe_n[1], 1'b1);
        $display("test fields done");
        for (int i = 0; i < 4; i++)
            wr(8'h3f + ((i == 3) ? 8'h04 : 8'(i)), 8'h05);
        ext <= 7'h00;
        settle();
        check({dsr_n, rxd, dcd_n, ri_n}, 4'h0);
        ext <= 7'h7f;
        settle();
        check({dsr_n, rxd, dcd_n, ri_n}, 4'hf);
        wr(`GPCFG_IDX_TX, 8'h04);
        wr(`GPCFG_IDX_RTS, 8'h04);
        txd <= 1'b0;
        rts_n <= 1'b0;
        settle();
        check({pin_oe_n[6], pin_oe_n[4], pin_o[6], pin_o[4]}, 4'h0);
        txd <= 1'b1;
        settle();
        check(pin_o[4], 1'b1);
        check(pin_o[6], 1'b0);
        wr(`GPCFG_IDX_RX, 8'h07);
        settle();
        check(rxd, 1'b0);
        wr(`GPCFG_IDX_CARRIER, 8'h80);
        check(pin_oe_n[2], 1'b0);
        wr(`GPCFG_IDX_DATA, 8'h04);
        check(pin_oe_n[2], 1'b1);
        $display("test routing done");
        wr(`GPCFG_IDX_MASK, 8'h01);
        wr(`GPCFG_IDX_LOCK, 8'h0d);
        ext[0] <= 1'b0;
        settle();
        check(irq, 1'b1);
        wr(`GPCFG_IDX_STATUS, 8'h01);
        check(irq, 1'b0);
        wr(`GPCFG_IDX_MASK, 8'h00);
        ext[0] <= 1'b1;
        settle();
        rd_chk(`GPCFG_IDX_STATUS, 8'h01, 8'h01);
        check(irq, 1'b0);
        wr(`GPCFG_IDX_STATUS, 8'h03);
        $display("test edge interrupt done");
        wr(`GPCFG_IDX_LOCK, 8'h06);
        check(pin_oe_n[0], 1'b1);
        wr(`GPCFG_IDX_LOCK, 8'h00);
        rd_chk(`GPCFG_IDX_LOCK, 8'h0c, 8'h04);
        rd_chk(`GPCFG_IDX_PINS, 8'h01, 8'h01);
        ext[0] <= 1'b0;
        settle();
        wr(`GPCFG_IDX_DDREG, 8'h5a);
        check(disable_register, 8'h5a);
        ext[0] <= 1'b1;
        settle();
        wr(`GPCFG_IDX_DDREG, 8'ha5);
        check(disable_register, 8'h5a);
        rd_chk(`GPCFG_IDX_STATUS, 8'h02, 8'h02);
        $display("test lock done");
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk(`GPCFG_IDX_LOCK, 8'hff, 8'h01);
        $display("test second reset done");
        stop_test();
    end
endmodule // gpio_pin_config_bank_tb_top

// file: src/gpcfg_bank.sv
// AHB-Lite slave holding seven pin configuration registers
//
// Local design decision: the AHB-Lite interface to the registers.
`include "gpcfg_map.svh"
module gpcfg_bank (
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic      [31:0]            hrdata,
    output logic                        hreadyout,
    output logic                        hresp,
    input  wire logic [6:0]             pin_i,
    output logic      [6:0]             pin_o,
    output logic      [6:0]             pin_oe_n,
    output logic                        port2_ring_indicator_n,
    output logic                        port2_carrier_detect_n,
    output logic                        port2_receive_data,
    input  wire logic                   port2_transmit_data,
    output logic                        port2_data_set_ready_n,
    input  wire logic                   port2_request_to_send_n,
    output gpcfg_pkg::gpcfg_byte_t      disable_register,
    output logic                        irq
);
    import gpcfg_pkg::*;

    default clocking cb_main @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    typedef struct packed {
        gpcfg_phase_t      phase;
        logic              wr;
        logic [7:0]        idx;
        logic [6:0][7:0]   cfg;
        logic [6:0]        data;
        gpcfg_byte_t       ddreg;
        logic [2:0]        status;
        logic [2:0]        mask;
        logic [6:0]        s1;
        logic [6:0]        s2;
        logic              lock_prev;
        logic [31:0]       rdata;
    } gpcfg_state_t;

    gpcfg_state_t st;
    gpcfg_state_t next_st;

    logic [6:0] force_in;
    logic [6:0] alt_drives;
    logic [6:0] alt_out;
    logic [6:0] pin_value;
    logic       lock_sel;
    logic       edge_sel;
    logic       edge_ev;
    logic       ddreg_locked;

    // Register index from a byte address: printed offsets are word indexes
    function automatic logic [7:0] word_idx(input logic [31:0] a);
        return a[9:2];
    endfunction

    function automatic logic is_func(input logic [7:0] c);
        return c[`GPCFG_ALT_HI:`GPCFG_ALT_LO] == `GPCFG_ALT_FUNC;
    endfunction

    always_comb begin
        lock_sel     = is_func(st.cfg[0]);
        edge_sel     = st.cfg[0][`GPCFG_ALT_HI:`GPCFG_ALT_LO]
                       == `GPCFG_ALT_EDGE;
        edge_ev      = edge_sel && (st.s2[0] != st.lock_prev);
        ddreg_locked = lock_sel && st.s2[0];
        force_in     = {6'b00_0000, lock_sel};
        alt_drives   = {is_func(st.cfg[6]), 1'b0, is_func(st.cfg[4]),
                        4'b0000};
        alt_out      = {port2_request_to_send_n, 1'b0,
                        port2_transmit_data, 4'b0000};
    end

    genvar g;
    generate
        for (g = 0; g < `GPCFG_NPINS; g++) begin : g_pin
            gpcfg_pin u_pin (
                .cfg        (st.cfg[g]),
                .force_in   (force_in[g]),
                .data_bit   (st.data[g]),
                .alt_out    (alt_out[g]),
                .alt_drives (alt_drives[g]),
                .pin_sync   (st.s2[g]),
                .pin_o      (pin_o[g]),
                .pin_oe_n   (pin_oe_n[g]),
                .pin_value  (pin_value[g])
            );
        end
    endgenerate

    // Inputs idle high when their pin is not routed to port 2
    always_comb begin
        port2_ring_indicator_n = is_func(st.cfg[1]) ? pin_value[1] : 1'b1;
        port2_carrier_detect_n = is_func(st.cfg[2]) ? pin_value[2] : 1'b1;
        port2_receive_data     = is_func(st.cfg[3]) ? pin_value[3] : 1'b1;
        port2_data_set_ready_n = is_func(st.cfg[5]) ? pin_value[5] : 1'b1;
        disable_register       = st.ddreg;
        hreadyout              = 1'b1;
        hresp                  = 1'b0;
        hrdata                 = st.rdata;
        irq                    = |(st.status & st.mask);
    end

    always_comb begin
        logic [7:0]  wb;
        logic [31:0] rd;
        logic [2:0]  ev;
        logic [7:0]  ri;
        next_st = st;
        wb = hwdata[7:0];
        rd = 32'h0000_0000;
        ev = 3'b000;
        ri = word_idx(haddr);
        next_st.s1 = pin_i;
        next_st.s2 = st.s1;
        next_st.lock_prev = st.s2[0];
        ev[`GPCFG_EV_EDGE] = edge_ev;
        // Data phase write
        if (st.phase == GPCFG_DATA && st.wr) begin
            if (st.idx == `GPCFG_IDX_LOCK) begin
                next_st.cfg[0] = wb & `GPCFG_WMASK;
                if (lock_sel) begin
                    next_st.cfg[0][`GPCFG_ALT_HI:`GPCFG_ALT_LO] =
                        `GPCFG_ALT_FUNC;
                end
            end else if (st.idx >= `GPCFG_IDX_RING &&
                         st.idx <= `GPCFG_IDX_RTS) begin
                next_st.cfg[3'(st.idx - `GPCFG_IDX_LOCK)] =
                    wb & `GPCFG_WMASK;
            end else if (st.idx == `GPCFG_IDX_DATA) begin
                next_st.data = wb[6:0];
            end else if (st.idx == `GPCFG_IDX_DDREG) begin
                if (ddreg_locked) begin
                    ev[`GPCFG_EV_DDREG_REJ] = 1'b1;
                end else begin
                    next_st.ddreg = wb;
                end
            end else if (st.idx == `GPCFG_IDX_STATUS) begin
                next_st.status = st.status & ~wb[2:0];
            end else if (st.idx == `GPCFG_IDX_MASK) begin
                next_st.mask = wb[2:0];
            end
        end
        // Set wins over a clear in the same cycle
        next_st.status = next_st.status | ev;
        // Address phase; reads look at next_st so that a read right
        // behind a write returns the value that write just landed
        next_st.phase = GPCFG_IDLE;
        if (hsel && hready && htrans[1]) begin
            next_st.phase = GPCFG_DATA;
            next_st.wr    = hwrite;
            next_st.idx   = ri;
            if (ri >= `GPCFG_IDX_LOCK && ri <= `GPCFG_IDX_RTS) begin
                rd = {24'h00_0000, next_st.cfg[3'(ri - `GPCFG_IDX_LOCK)]};
            end else if (ri == `GPCFG_IDX_DATA) begin
                rd = {25'h000_0000, next_st.data};
            end else if (ri == `GPCFG_IDX_DDREG) begin
                rd = {24'h00_0000, next_st.ddreg};
            end else if (ri == `GPCFG_IDX_STATUS) begin
                rd = {29'h0000_0000, next_st.status};
            end else if (ri == `GPCFG_IDX_MASK) begin
                rd = {29'h0000_0000, next_st.mask};
            end else if (ri == `GPCFG_IDX_PINS) begin
                rd = {24'h00_0000, ddreg_locked, pin_value};
            end
            next_st.rdata = rd;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st           <= '0;
            st.cfg[0]    <= `GPCFG_RST_CFG;
            st.cfg[1]    <= `GPCFG_RST_CFG;
            st.cfg[2]    <= `GPCFG_RST_CFG;
            st.cfg[3]    <= `GPCFG_RST_CFG;
            st.cfg[4]    <= `GPCFG_RST_TX;
            st.cfg[5]    <= `GPCFG_RST_CFG;
            st.cfg[6]    <= `GPCFG_RST_CFG;
            st.s1        <= 7'h7f;
            st.s2        <= 7'h7f;
            st.lock_prev <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    lock_holds_a: assert property (@(posedge hclk) disable iff (!hresetn)
        is_func(st.cfg[0]) |=> is_func(st.cfg[0]))
        else $error("lockable field left disable control");
    ddreg_ro_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.phase == GPCFG_DATA && st.wr && st.idx == `GPCFG_IDX_DDREG
         && ddreg_locked) |=> $stable(st.ddreg) && st.status[1])
        else $error("locked disable register changed");
    ddreg_rw_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.phase == GPCFG_DATA && st.wr && st.idx == `GPCFG_IDX_DDREG
         && !ddreg_locked) |=> st.ddreg == $past(hwdata[7:0]))
        else $error("disable register write lost");
    lock_input_a: assert property (@(posedge hclk) disable iff (!hresetn)
        lock_sel |-> pin_oe_n[0] && pin_value[0] == st.s2[0])
        else $error("lockable pin not plain input");
    dir_in_a: assert property (@(posedge hclk) disable iff (!hresetn)
        st.cfg[1][0] |-> pin_oe_n[1])
        else $error("input pin driven");
    od_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.cfg[2][7] && pin_o[2]) |-> pin_oe_n[2])
        else $error("open drain drove high");
    pol_inv_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (is_func(st.cfg[3]) && st.cfg[3][1]) |->
        port2_receive_data != st.s2[3])
        else $error("polarity not applied");
    tx_route_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (is_func(st.cfg[4]) && !st.cfg[4][1]) |->
        pin_o[4] == port2_transmit_data)
        else $error("transmit not routed");
    rsv_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        st.cfg[6][6:4] == 3'b000)
        else $error("reserved bits set");

    // Multi-step checks are built from these
    sequence addr_taken_s;
        hsel && hready && htrans[1];
    endsequence
    sequence ddreg_wr_s;
        st.phase == GPCFG_DATA && st.wr && st.idx == `GPCFG_IDX_DDREG;
    endsequence
    sequence mask_wr_s;
        st.phase == GPCFG_DATA && st.wr && st.idx == `GPCFG_IDX_MASK;
    endsequence
    sequence edge_seen_s;
        edge_sel && st.s2[0] != st.lock_prev;
    endsequence
    sequence pin0_high_s;
        lock_sel && st.s2[0];
    endsequence
    sequence pin0_low_s;
        !(lock_sel && st.s2[0]);
    endsequence

    bus_okay_a: assert property (
        hreadyout && !hresp)
        else $error("bus not ready or not okay");
    addr_take_a: assert property (
        addr_taken_s |=> st.phase == GPCFG_DATA)
        else $error("address phase not taken");
    phase_idle_a: assert property (
        !(hsel && hready && htrans[1]) |=> st.phase == GPCFG_IDLE)
        else $error("data phase without request");
    cfg_quiet_a: assert property (
        !(st.phase == GPCFG_DATA && st.wr) |=> $stable(st.cfg))
        else $error("config changed without write");
    ddreg_quiet_a: assert property (
        !(st.phase == GPCFG_DATA && st.wr &&
          st.idx == `GPCFG_IDX_DDREG) |=> $stable(st.ddreg))
        else $error("disable register changed without write");
    ddreg_lock_a: assert property (
        ddreg_wr_s ##0 pin0_high_s |=> st.ddreg == $past(st.ddreg))
        else $error("locked disable register took a write");
    ddreg_open_a: assert property (
        ddreg_wr_s ##0 pin0_low_s |=> st.ddreg == $past(hwdata[7:0]))
        else $error("open disable register missed a write");
    mask_load_a: assert property (
        mask_wr_s |=> st.mask == $past(hwdata[2:0]))
        else $error("mask write lost");
    edge_set_a: assert property (
        edge_seen_s |=> st.status[`GPCFG_EV_EDGE])
        else $error("pin edge did not set status");
    irq_out_a: assert property (
        (st.status & st.mask) != 3'b000 |-> irq)
        else $error("unmasked event without interrupt");
    reset_vals_a: assert property (
        $rose(hresetn) |-> st.cfg[0] == `GPCFG_RST_CFG &&
        st.cfg[2] == `GPCFG_RST_CFG &&
        st.cfg[4] == `GPCFG_RST_TX)
        else $error("config not at reset value");
    ring_route_a: assert property (
        is_func(st.cfg[1]) |->
        port2_ring_indicator_n == (st.s2[1] ^ st.cfg[1][1]))
        else $error("ring indicator not routed");
    ring_idle_a: assert property (
        !is_func(st.cfg[1]) |-> port2_ring_indicator_n)
        else $error("ring indicator not idle");
    carrier_route_a: assert property (
        is_func(st.cfg[2]) |->
        port2_carrier_detect_n == (st.s2[2] ^ st.cfg[2][1]))
        else $error("carrier detect not routed");
    carrier_idle_a: assert property (
        !is_func(st.cfg[2]) |-> port2_carrier_detect_n)
        else $error("carrier detect not idle");
    rx_route_a: assert property (
        is_func(st.cfg[3]) |->
        port2_receive_data == (st.s2[3] ^ st.cfg[3][1]))
        else $error("receive data not routed");
    rx_idle_a: assert property (
        !is_func(st.cfg[3]) |-> port2_receive_data)
        else $error("receive data not idle");
    dsr_route_a: assert property (
        is_func(st.cfg[5]) |->
        port2_data_set_ready_n == (st.s2[5] ^ st.cfg[5][1]))
        else $error("data set ready not routed");
    dsr_idle_a: assert property (
        !is_func(st.cfg[5]) |-> port2_data_set_ready_n)
        else $error("data set ready not idle");
    rts_route_a: assert property (
        (is_func(st.cfg[6]) && !st.cfg[6][1]) |->
        pin_o[6] == port2_request_to_send_n)
        else $error("request to send not routed");
    dir_out_a: assert property (
        (!st.cfg[1][0] && !st.cfg[1][7]) |-> !pin_oe_n[1])
        else $error("output pin not driven");
    push_pull_a: assert property (
        (!st.cfg[2][0] && !st.cfg[2][7]) |-> !pin_oe_n[2])
        else $error("push-pull pin not driven");

    // Write mask keeps these clear on every pin
    generate
        for (g = 0; g < `GPCFG_NPINS; g++) begin : g_rsv
            rsv_bits_a: assert property (
                st.cfg[g][6:4] == 3'b000)
                else $error("reserved config bits set");
        end
    endgenerate
endmodule // gpcfg_bank

// file: src/gpcfg_map.svh
// Register map, field positions and reset values of the pin config bank
`ifndef GPCFG_MAP_SVH
`define GPCFG_MAP_SVH
`define GPCFG_NPINS        7
`define GPCFG_IDX_LOCK     8'h3e
`define GPCFG_IDX_RING     8'h3f
`define GPCFG_IDX_CARRIER  8'h40
`define GPCFG_IDX_RX       8'h41
`define GPCFG_IDX_TX       8'h42
`define GPCFG_IDX_DSR      8'h43
`define GPCFG_IDX_RTS      8'h44
`define GPCFG_IDX_DATA     8'h50
`define GPCFG_IDX_DDREG    8'h51
`define GPCFG_IDX_STATUS   8'h52
`define GPCFG_IDX_MASK     8'h53
`define GPCFG_IDX_PINS     8'h54
`define GPCFG_BIT_DIR      0
`define GPCFG_BIT_POL      1
`define GPCFG_ALT_LO       2
`define GPCFG_ALT_HI       3
`define GPCFG_BIT_OD       7
`define GPCFG_ALT_GPIO     2'b00
`define GPCFG_ALT_FUNC     2'b01
`define GPCFG_ALT_EDGE     2'b11
`define GPCFG_RST_CFG      8'h01
`define GPCFG_RST_TX       8'h00
`define GPCFG_WMASK        8'h8f
`define GPCFG_EV_EDGE      0
`define GPCFG_EV_DDREG_REJ 1
`define GPCFG_EV_W         2
`endif

// file: src/gpcfg_pin.sv
// One pin: config decode, polarity, direction and driver type
`include "gpcfg_map.svh"
module gpcfg_pin (
    input  wire logic [7:0] cfg,
    input  wire logic       force_in,
    input  wire logic       data_bit,
    input  wire logic       alt_out,
    input  wire logic       alt_drives,
    input  wire logic       pin_sync,
    output logic            pin_o,
    output logic            pin_oe_n,
    output logic            pin_value
);
    logic out_mode;
    logic pol;
    logic src;
    logic drv;
    always_comb begin
        out_mode  = !cfg[`GPCFG_BIT_DIR] && !force_in;
        pol       = cfg[`GPCFG_BIT_POL] && !force_in;
        src       = (alt_drives ? alt_out : data_bit) ^ pol;
        pin_value = pin_sync ^ pol;
        drv       = out_mode && (!cfg[`GPCFG_BIT_OD] || !src);
        pin_o     = src;
        pin_oe_n  = !drv;
    end
endmodule // gpcfg_pin

// file: src/gpcfg_pkg.sv
// Types of the pin config bank
package gpcfg_pkg;
    typedef enum logic [1:0] {
        GPCFG_IDLE = 2'b00,
        GPCFG_DATA = 2'b01
    } gpcfg_phase_t;
    typedef logic [7:0] gpcfg_byte_t;
endpackage
